// ==== clk_path_pkg.sv ====
`default_nettype none
package clk_path_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] PLL_FIRST_IDX   = 10'h010;
  localparam logic [9:0] PLL_LAST_IDX    = 10'h01E;
  localparam logic [9:0] PLL_POWER_IDX   = 10'h010;
  localparam logic [9:0] VCO_CAL_IDX     = 10'h018;
  localparam logic [9:0] VCO_DIV_IDX     = 10'h1E0;
  localparam logic [9:0] SRC_SEL_IDX     = 10'h1E1;
  localparam logic [9:0] UPDATE_IDX      = 10'h232;
  localparam logic [9:0] STATUS_IDX      = 10'h233;
  localparam int         PLL_CNT         = 15;
  localparam int         ADDR_W          = 12;

  // field positions
  localparam int POWER_LSB    = 0;
  localparam int PUMP_LSB     = 4;
  localparam int POLARITY_BIT = 7;
  localparam int CAL_BIT      = 0;
  localparam int BYPASS_BIT   = 0;
  localparam int SOURCE_BIT   = 1;
  localparam int UPDATE_BIT   = 0;

  // reset values, run code and ratio limits
  localparam logic [7:0] PLL_POWER_RST = 8'h01;
  localparam logic [7:0] PLL_OTHER_RST = 8'h00;
  localparam logic [7:0] VCO_DIV_RST   = 8'h02;
  localparam logic [7:0] SRC_SEL_RST   = 8'h00;
  localparam logic [1:0] POWER_ON      = 2'h0;
  localparam logic [2:0] RATIO_RST     = 3'h4;
  localparam logic [2:0] RATIO_MIN     = 3'h2;
  localparam logic [2:0] RATIO_MAX     = 3'h6;

  typedef struct packed {
    logic       pll_off;
    logic       pfd_negative;
    logic [2:0] pump_mode;
    logic [2:0] vco_div_ratio;
    logic       div_bypass;
    logic       source_vco;
    logic       vco_enable;
    logic       ext_to_prescaler;
  } clk_path_t;

  localparam clk_path_t PATH_RST = '{pll_off: 1'b1, pfd_negative: 1'b0, pump_mode: 3'h0,
                                     vco_div_ratio: RATIO_RST, div_bypass: 1'b0,
                                     source_vco: 1'b0, vco_enable: 1'b0,
                                     ext_to_prescaler: 1'b0};

  typedef struct packed {
    logic [PLL_CNT-1:0][7:0] pll;
    logic [7:0]              vdiv;
    logic [7:0]              src;
    clk_path_t               path;
    logic                    cal_act;
    logic                    cal_start;
    logic [7:0]              cal_count;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } state_t;

endpackage
`default_nettype wire

// ==== clock_path_config_control.sv ====
// How it works
// RL1: after reset the PLL is off and the external input runs through the VCO divider.
// RL2: power field 01b powers the PLL down, 00b runs it; resets to 01b.
// RL3: divider code picks divide 2 to 6; resets to 010b meaning divide-by-4.
// RL4: bypass bit clear uses the VCO divider, set bypasses it.
// RL5: source bit clear picks the external input, set picks the internal VCO.
// RL6: PFD polarity bit clear is positive, set is negative.
// RL7: written values take effect only when 0x01 is written to the update register.
// RL8: through the VCO divider the division is never below two.
// RL9: PLL on with external source keeps the VCO off, input straight to prescaler.
// RL10: software keeps channel divider input at or below 1600 MHz.
// RL11: external clock through the VCO divider stays at or below 2400 MHz.
// RL12: calibrate bit set then update starts a VCO calibration.
// RL13: before each later calibration software clears the bit and updates first.
// RL14: software calibrates whenever the internal VCO is selected.
// RL15: indices pll_power_polarity_ctrl to 0x01E hold the PLL settings.
// RL16: writing defaults back then updating restores the reset configuration.
// RL17: during calibration the reference is present and the divider not static.
// RL18: update copies every staged field to the active copy in one step; code copies only indices 0x010, 0x018, divider and source.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module clock_path_config_control (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [clk_path_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                       pwdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic [31:0]                            prdata,
  output clk_path_pkg::clk_path_t                path,
  output logic                                   cal_start
);

  clk_path_pkg::state_t st;
  clk_path_pkg::state_t next_st;

  logic [9:0] idx;
  logic       done;
  logic       wr;
  logic       upd;

  function automatic logic mapped(input logic [9:0] i);
    mapped = (i >= clk_path_pkg::PLL_FIRST_IDX && i <= clk_path_pkg::PLL_LAST_IDX)
             || i == clk_path_pkg::VCO_DIV_IDX || i == clk_path_pkg::SRC_SEL_IDX
             || i == clk_path_pkg::UPDATE_IDX || i == clk_path_pkg::STATUS_IDX;
  endfunction

  // illegal codes fall back to the smallest legal ratio, never below two
  function automatic logic [2:0] ratio_of(input logic [2:0] code);
    unique case (code)
      3'h0:    ratio_of = 3'h2;
      3'h1:    ratio_of = 3'h3;
      3'h2:    ratio_of = 3'h4;
      3'h3:    ratio_of = 3'h5;
      3'h4:    ratio_of = 3'h6;
      default: ratio_of = clk_path_pkg::RATIO_MIN;
    endcase
  endfunction

  assign idx  = paddr[11:2];
  assign done = psel && penable && st.pready;
  assign wr   = done && pwrite && mapped(idx);
  assign upd  = wr && idx == clk_path_pkg::UPDATE_IDX && pwdata[clk_path_pkg::UPDATE_BIT];

  always_comb begin
    logic [7:0] p0;
    logic       new_src;
    logic       new_off;
    logic       new_cal;
    p0      = 8'h00;
    new_src = 1'b0;
    new_off = 1'b0;
    new_cal = 1'b0;
    next_st = st;
    next_st.cal_start = 1'b0;
    // answer one cycle after setup, so no wait states
    next_st.pready  = psel && !penable;
    next_st.pslverr = psel && !penable && !mapped(idx);
    next_st.prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      // RL15 PLL range
      for (int i = 0; i < clk_path_pkg::PLL_CNT; i++) begin
        if (idx == clk_path_pkg::PLL_FIRST_IDX + 10'(i)) begin
          next_st.prdata = {24'h00_0000, st.pll[i]};
        end
      end
      if (idx == clk_path_pkg::VCO_DIV_IDX) begin
        next_st.prdata = {24'h00_0000, st.vdiv};
      end
      if (idx == clk_path_pkg::SRC_SEL_IDX) begin
        next_st.prdata = {24'h00_0000, st.src};
      end
      if (idx == clk_path_pkg::STATUS_IDX) begin
        next_st.prdata = {11'h000, st.cal_count, st.cal_act, st.path};
      end
    end
    if (!done) begin
      next_st.pready  = next_st.pready;
    end else begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end
    if (wr) begin
      // RL7 staged only
      for (int i = 0; i < clk_path_pkg::PLL_CNT; i++) begin
        if (idx == clk_path_pkg::PLL_FIRST_IDX + 10'(i)) begin
          next_st.pll[i] = pwdata[7:0];
        end
      end
      if (idx == clk_path_pkg::VCO_DIV_IDX) begin
        next_st.vdiv = pwdata[7:0];
      end
      if (idx == clk_path_pkg::SRC_SEL_IDX) begin
        next_st.src = pwdata[7:0];
      end
    end
    // RL18 indices 0x010, 0x018, divider and source at once
    if (upd) begin
      p0      = st.pll[0];
      new_src = st.src[clk_path_pkg::SOURCE_BIT];
      new_off = p0[clk_path_pkg::POWER_LSB +: 2] != clk_path_pkg::POWER_ON;
      new_cal = st.pll[clk_path_pkg::VCO_CAL_IDX - clk_path_pkg::PLL_FIRST_IDX]
                [clk_path_pkg::CAL_BIT];
      // RL2 power field
      next_st.path.pll_off = new_off;
      // RL6 polarity
      next_st.path.pfd_negative = p0[clk_path_pkg::POLARITY_BIT];
      next_st.path.pump_mode    = p0[clk_path_pkg::PUMP_LSB +: 3];
      // RL3 RL8 divide ratio
      next_st.path.vco_div_ratio = ratio_of(st.vdiv[2:0]);
      // RL4 divider bypass
      next_st.path.div_bypass = st.src[clk_path_pkg::BYPASS_BIT];
      // RL5 source select
      next_st.path.source_vco = new_src;
      // RL9 vco off for external
      next_st.path.vco_enable       = !new_off && new_src;
      next_st.path.ext_to_prescaler = !new_off && !new_src;
      // RL12 RL13 start on rising bit only
      next_st.cal_act   = new_cal;
      next_st.cal_start = new_cal && !st.cal_act;
      if (new_cal && !st.cal_act) begin
        next_st.cal_count = st.cal_count + 8'h01;
      end
    end
  end

  // RL1 RL16 defaults match the reset copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.pll[0]    <= clk_path_pkg::PLL_POWER_RST;
      st.vdiv      <= clk_path_pkg::VCO_DIV_RST;
      st.src       <= clk_path_pkg::SRC_SEL_RST;
      st.path      <= clk_path_pkg::PATH_RST;
    end else begin
      st <= next_st;
    end
  end

  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign prdata    = st.prdata;
  assign path      = st.path;
  assign cal_start = st.cal_start;

  reset_defaults_a : assert property (@(posedge pclk) $rose(presetn) |->  // RL1
    st.path.pll_off && !st.path.source_vco && !st.path.div_bypass
    && st.path.vco_div_ratio == clk_path_pkg::RATIO_RST)
    else $error("path not at defaults after reset");

  power_field_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL2
    upd && st.pll[0][1:0] == 2'h1 |=> st.path.pll_off && !st.path.vco_enable)
    else $error("power-down code did not stop the pll");

  ratio_map_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL3
    upd && st.vdiv[2:0] == 3'h2 |=> st.path.vco_div_ratio == 3'h4)
    else $error("divider code 2 not divide-by-4");

  staged_copy_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL18
    upd |=> st.path.div_bypass == $past(st.src[0])
            && st.path.source_vco == $past(st.src[1]))
    else $error("source or bypass not copied on update");

  no_early_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL7
    !upd |=> $stable(st.path))
    else $error("active path changed without update");

  polarity_copy_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL6
    upd |=> st.path.pfd_negative == $past(st.pll[0][7]))
    else $error("pfd polarity not applied");

  ratio_range_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL8
    st.path.vco_div_ratio >= 3'h2 && st.path.vco_div_ratio <= 3'h6)
    else $error("vco divide ratio out of range");

  vco_idle_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL9
    !st.path.source_vco |-> !st.path.vco_enable
    && (st.path.ext_to_prescaler == !st.path.pll_off))
    else $error("vco powered while external source used");

  cal_kick_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL12
    upd && st.pll[8][0] && !st.cal_act |=> cal_start ##1 !cal_start)
    else $error("calibration start not a single pulse");

  answer_time_a : assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not exactly one cycle after setup");

  power_run_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL2
    upd && st.pll[0][1:0] == 2'h0
    |=> !st.path.pll_off)
    else $error("run code did not power the pll");

  power_high_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL2
    upd && st.pll[0][1]
    |=> st.path.pll_off)
    else $error("power codes 10b and 11b did not stop the pll");

  ratio_two_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL3
    upd && st.vdiv[2:0] == 3'h0
    |=> st.path.vco_div_ratio == 3'h2)
    else $error("divider code 0 not divide-by-2");

  ratio_three_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL3
    upd && st.vdiv[2:0] == 3'h1
    |=> st.path.vco_div_ratio == 3'h3)
    else $error("divider code 1 not divide-by-3");

  ratio_five_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL3
    upd && st.vdiv[2:0] == 3'h3
    |=> st.path.vco_div_ratio == 3'h5)
    else $error("divider code 3 not divide-by-5");

  ratio_six_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL3
    upd && st.vdiv[2:0] == 3'h4
    |=> st.path.vco_div_ratio == 3'h6)
    else $error("divider code 4 not divide-by-6");

  ratio_illegal_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL8
    upd && st.vdiv[2:0] > 3'h4
    |=> st.path.vco_div_ratio == clk_path_pkg::RATIO_MIN)
    else $error("illegal divider code not held at divide-by-2");

  bypass_set_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL4
    upd && st.src[clk_path_pkg::BYPASS_BIT]
    |=> st.path.div_bypass)
    else $error("bypass bit did not bypass the vco divider");

  source_vco_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL5
    upd && st.src[clk_path_pkg::SOURCE_BIT]
    |=> st.path.source_vco)
    else $error("source bit did not pick the internal vco");

  pump_copy_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL15
    upd
    |=> st.path.pump_mode == $past(st.pll[0][6:4]))
    else $error("pump mode not applied on update");

  vco_on_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL9
    st.path.source_vco
    |-> (st.path.vco_enable == !st.path.pll_off) && !st.path.ext_to_prescaler)
    else $error("vco source path inconsistent");

  pll_off_quiet_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL9
    st.path.pll_off
    |-> !st.path.vco_enable && !st.path.ext_to_prescaler)
    else $error("pll off but loop path still driven");

  src_write_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL7
    wr && idx == clk_path_pkg::SRC_SEL_IDX
    |=> st.src == $past(pwdata[7:0]))
    else $error("source byte not staged on write");

  vdiv_write_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL7
    wr && idx == clk_path_pkg::VCO_DIV_IDX
    |=> st.vdiv == $past(pwdata[7:0]))
    else $error("divider byte not staged on write");

  cal_write_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL15
    wr && idx == clk_path_pkg::VCO_CAL_IDX
    |=> st.pll[8] == $past(pwdata[7:0]))
    else $error("calibrate byte not staged on write");

  pll_last_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL15
    wr && idx == clk_path_pkg::PLL_LAST_IDX
    |=> st.pll[14] == $past(pwdata[7:0]))
    else $error("last pll byte not staged on write");

  unmapped_err_a : assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped(idx)
    |=> pslverr && pready)
    else $error("unmapped index answered without error");

  unmapped_keep_a : assert property (@(posedge pclk) disable iff (!presetn)
    done && pwrite && !mapped(idx)
    |=> $stable(st.pll) && $stable(st.vdiv) && $stable(st.src))
    else $error("unmapped write changed a staged byte");

  read_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    !pready
    |-> prdata == 32'h0000_0000)
    else $error("read data driven outside the answer cycle");

  err_ready_a : assert property (@(posedge pclk) disable iff (!presetn)
    pslverr
    |-> pready)
    else $error("error flag without ready");

  cal_quiet_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL12
    !upd
    |=> !cal_start)
    else $error("calibration started without update");

  cal_again_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL13
    upd && st.cal_act
    |=> !cal_start)
    else $error("calibration restarted without clear");

  cal_count_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL12
    cal_start
    |-> st.cal_count == $past(st.cal_count) + 8'h01)
    else $error("calibration start not counted");

  reset_staged_a : assert property (@(posedge pclk)  // RL1
    $rose(presetn)
    |-> st.pll[0] == clk_path_pkg::PLL_POWER_RST && st.vdiv == clk_path_pkg::VCO_DIV_RST
        && st.src == clk_path_pkg::SRC_SEL_RST)
    else $error("staged bytes not at defaults after reset");

  reset_bus_a : assert property (@(posedge pclk)  // RL1
    $rose(presetn)
    |-> !pready && !pslverr && !cal_start && prdata == 32'h0000_0000)
    else $error("bus outputs not idle after reset");

  defaults_restore_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL16
    upd && st.pll[0] == clk_path_pkg::PLL_POWER_RST && st.vdiv == clk_path_pkg::VCO_DIV_RST
    && st.src == clk_path_pkg::SRC_SEL_RST |=> st.path == clk_path_pkg::PATH_RST)
    else $error("default bytes did not restore the reset path");

  upd_ignored_a : assert property (@(posedge pclk) disable iff (!presetn)  // RL7
    wr && idx == clk_path_pkg::UPDATE_IDX && !pwdata[clk_path_pkg::UPDATE_BIT]
    |=> !cal_start && $stable(st.path))
    else $error("update without bit 0 took effect");

endmodule
`default_nettype wire

// ==== ext_clock_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ext_clock_model #(
  parameter int SRC_MHZ = 2400
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire clk_path_pkg::clk_path_t path,
  input  wire logic                    cal_start,
  output logic [11:0]                  chan_mhz,
  output logic [7:0]                   cal_seen
);
  assign chan_mhz = path.div_bypass ? 12'(SRC_MHZ)
                                    : 12'(SRC_MHZ / int'(path.vco_div_ratio));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_seen <= 8'h00;
    end else if (cal_start === 1'b1) begin
      cal_seen <= cal_seen + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== clock_path_config_control_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module clock_path_config_control_tb;
  localparam logic [9:0] PWR = clk_path_pkg::PLL_POWER_IDX;
  localparam logic [9:0] CAL = clk_path_pkg::VCO_CAL_IDX;
  localparam logic [9:0] DIV = clk_path_pkg::VCO_DIV_IDX;
  localparam logic [9:0] SRC = clk_path_pkg::SRC_SEL_IDX;
  localparam logic [9:0] UPD = clk_path_pkg::UPDATE_IDX;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [11:0]             paddr = 12'h000;
  logic [31:0]             pwdata = 32'h0;
  logic                    pready, pslverr, cal_start, err;
  logic [31:0]             prdata, rd;
  logic [11:0]             chan_mhz;
  logic [7:0]              cal_seen;
  clk_path_pkg::clk_path_t path, e;
  int                      num_errors = 0;
  int                      checks = 0;
  int                      cyc = 0;

  always #5 pclk = ~pclk;

  clock_path_config_control clock_path_config_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .path(path), .cal_start(cal_start));

  ext_clock_model #(.SRC_MHZ(2400)) ext_clock_model_inst (
    .pclk(pclk), .presetn(presetn), .path(path), .cal_start(cal_start),
    .chan_mhz(chan_mhz), .cal_seen(cal_seen));

  task automatic close_out();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // waits on pready with no fixed latency assumed
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no limit of its own; pready high or the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  task automatic upd_settle();
    wr(UPD, 8'h01);
    repeat (2) @(posedge pclk);
    #1;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk(32'(path), 32'(clk_path_pkg::PATH_RST));
    rdc(PWR, 32'h01);
    rdc(DIV, 32'h02);
    rdc(SRC, 32'h00);
    chk(32'(chan_mhz), 32'd600);
    wr(PWR, 8'hB0);
    wr(DIV, 8'h00);
    wr(SRC, 8'h03);
    chk(32'(path), 32'(clk_path_pkg::PATH_RST));
    wr(UPD, 8'h00);
    chk(32'(path), 32'(clk_path_pkg::PATH_RST));
    rdc(UPD, 32'h00);
    upd_settle();
    e = '{1'b0, 1'b1, 3'h3, 3'h2, 1'b1, 1'b1, 1'b1, 1'b0};
    chk(32'(path), 32'(e));
    wr(PWR, 8'h00);
    wr(SRC, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(DIV, 8'(c));
      upd_settle();
      e = '{1'b0, 1'b0, 3'h0, (c < 5) ? 3'(c + 2) : 3'h2, 1'b0, 1'b0, 1'b0, 1'b1};
      chk(32'(path), 32'(e));
      chk(32'(chan_mhz), 32'(2400 / ((c < 5) ? c + 2 : 2)));
      chk(32'(chan_mhz <= 12'h640), 32'h1);
    end
    wr(SRC, 8'h02);
    wr(CAL, 8'h01);
    upd_settle();
    chk(32'(cal_seen), 32'h1);
    chk(32'(path.div_bypass), 32'h0);
    upd_settle();
    chk(32'(cal_seen), 32'h1);
    wr(CAL, 8'h00);
    upd_settle();
    wr(CAL, 8'h01);
    upd_settle();
    chk(32'(cal_seen), 32'h2);
    for (int i = 0; i < clk_path_pkg::PLL_CNT; i++) wr(PWR + 10'(i), 8'(32'hA0 + i));
    for (int i = 0; i < clk_path_pkg::PLL_CNT; i++) rdc(PWR + 10'(i), 32'hA0 + i);
    for (int i = 0; i < clk_path_pkg::PLL_CNT; i++) wr(PWR + 10'(i), (i == 0) ? 8'h01 : 8'h00);
    wr(DIV, 8'h02);
    wr(SRC, 8'h00);
    upd_settle();
    chk(32'(path), 32'(clk_path_pkg::PATH_RST));
    rdc(clk_path_pkg::STATUS_IDX, {11'h000, 8'h02, 1'b0, clk_path_pkg::PATH_RST});
    xfer(1'b0, 10'h020, 8'h00);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
